// ===== hdl/spsp_port.sv
`timescale 1ns/100ps
module spsp_port #(
  parameter int EOW_CYCLES = spsp_pkg::EOW_CYCLES_DEF
) (
  // core clock and control
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          ce_in,
  input  wire logic                          test_mode_in,
  // link side
  input  wire logic                          link_clk_in,
  input  wire logic                          supply_high_in,
  output logic                               reply_bit_out,
  output logic                               reply_oe_out,
  // received frames
  output logic                               frame_valid_out,
  input  wire logic                          frame_ready_in,
  output logic [spsp_pkg::WORD_BITS-1:0]     frame_data_out,
  output logic                               frame_stop_out,
  // reply word to send
  input  wire logic                          reply_valid_in,
  output logic                               reply_ready_out,
  input  wire logic [spsp_pkg::WORD_BITS-1:0] reply_word_in,
  // soft reset request
  output logic                               soft_reset_out
);
  import spsp_pkg::*;

  localparam logic [CNT_W-1:0] EOW_CNT = CNT_W'(EOW_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

  // core domain state
  logic [16:0] buf_mem [2];
  logic        wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0]  fill, next_fill;
  logic        fack_tgl, next_fack_tgl;
  logic [15:0] rep_word, next_rep_word;
  logic        rep_tgl, next_rep_tgl;
  logic        soft_rst, next_soft_rst;
  logic        fr_s1, fr_s2, rack_s1, rack_s2;
  logic        do_wr, do_rd;

  // link domain state
  logic        lrst_s1, lrst_s2, tm_s1, tm_s2, ce_s1, ce_s2;
  logic        sup_s1, sup_s2, sup_d;
  logic        fack_s1, fack_s2, rep_s1, rep_s2;
  spsp_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt, high_cnt, next_high_cnt, low_prev, next_low_prev;
  logic [16:0] rx_sr, next_rx_sr, frame_hold, next_frame_hold;
  logic [4:0]  nbits, next_nbits, tx_left, next_tx_left;
  logic [15:0] tx_sr, next_tx_sr;
  logic        reply, next_reply, freq_tgl, next_freq_tgl, rack_tgl, next_rack_tgl;

  // ---------------- link domain ----------------
  // supply level is asynchronous to the link clock, so it is synchronised first
  always_ff @(posedge link_clk_in) begin
    lrst_s1 <= rst_n_in;
    lrst_s2 <= lrst_s1;
    tm_s1   <= test_mode_in;
    tm_s2   <= tm_s1;
    ce_s1   <= ce_in;
    ce_s2   <= ce_s1;
    sup_s1  <= supply_high_in;
    sup_s2  <= sup_s1;
    fack_s1 <= fack_tgl;
    fack_s2 <= fack_s1;
    rep_s1  <= rep_tgl;
    rep_s2  <= rep_s1;
  end

  always_comb begin
    logic rise, fall;
    rise            = sup_s2 & ~sup_d;
    fall            = ~sup_s2 & sup_d;
    next_state      = state;
    next_cnt        = cnt;
    next_high_cnt   = high_cnt;
    next_low_prev   = low_prev;
    next_rx_sr      = rx_sr;
    next_nbits      = nbits;
    next_tx_sr      = tx_sr;
    next_tx_left    = tx_left;
    next_reply      = reply;
    next_frame_hold = frame_hold;
    next_freq_tgl   = freq_tgl;
    next_rack_tgl   = rack_tgl;
    if (!tm_s2) begin
      next_state = SPSP_IDLE;
      next_nbits = NBITS_RST;
      next_reply = REPLY_IDLE;
    end else begin
      unique case (state)
        SPSP_IDLE: begin
          if (nbits == NBITS_RST && rep_s2 != rack_tgl) begin
            next_reply    = rep_word[15];
            next_tx_sr    = {rep_word[14:0], 1'b0};
            next_tx_left  = TX_LEFT_LOAD;
            next_rack_tgl = rep_s2;
          end
          if (rise) begin
            next_state = SPSP_HIGH;
            next_cnt   = CNT_ONE;
          end
        end
        SPSP_HIGH: begin
          next_cnt = cnt + CNT_ONE;
          // a supply that just stays high is normal operation, not a bit
          if (cnt == EOW_CNT) begin
            next_state = SPSP_IDLE;
            next_nbits = NBITS_RST;
          end else if (fall) begin
            next_high_cnt = cnt;
            next_cnt      = CNT_ONE;
            next_state    = SPSP_LOW;
          end
        end
        SPSP_LOW: begin
          next_cnt = cnt + CNT_ONE;
          if (rise) begin
            next_rx_sr    = {rx_sr[15:0], high_cnt > cnt};
            next_nbits    = (nbits == NBITS_FULL) ? nbits : nbits + 5'h01;
            next_low_prev = cnt;
            next_reply    = (tx_left != NBITS_RST) ? tx_sr[15] : REPLY_IDLE;
            next_tx_sr    = {tx_sr[14:0], 1'b0};
            if (tx_left != NBITS_RST)
              next_tx_left = tx_left - 5'h01;
            next_cnt      = CNT_ONE;
            next_state    = SPSP_HIGH;
          end else if (cnt == EOW_CNT) begin
            // long low closes the word; the stop bit is judged against the last low
            next_rx_sr = {rx_sr[15:0], high_cnt > low_prev};
            // a frame waiting for the core is kept; the new one is lost
            if (nbits >= NBITS_FULL - 5'h01 && freq_tgl == fack_s2) begin
              next_frame_hold = {rx_sr[15:0], high_cnt > low_prev};
              next_freq_tgl   = ~freq_tgl;
            end
            next_nbits   = NBITS_RST;
            next_tx_left = NBITS_RST;
            next_reply   = REPLY_IDLE;
            next_state   = SPSP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_s2) begin
      state      <= SPSP_IDLE;
      sup_d      <= 1'b0;
      cnt        <= '0;
      high_cnt   <= '0;
      low_prev   <= '0;
      rx_sr      <= FRAME_RST;
      nbits      <= NBITS_RST;
      tx_sr      <= WORD_RST;
      tx_left    <= NBITS_RST;
      reply      <= REPLY_IDLE;
      frame_hold <= FRAME_RST;
      freq_tgl   <= 1'b0;
      rack_tgl   <= 1'b0;
      reply_oe_out <= 1'b0;
    end else if (ce_s2) begin
      state      <= next_state;
      sup_d      <= sup_s2;
      cnt        <= next_cnt;
      high_cnt   <= next_high_cnt;
      low_prev   <= next_low_prev;
      rx_sr      <= next_rx_sr;
      nbits      <= next_nbits;
      tx_sr      <= next_tx_sr;
      tx_left    <= next_tx_left;
      reply      <= next_reply;
      frame_hold <= next_frame_hold;
      freq_tgl   <= next_freq_tgl;
      rack_tgl   <= next_rack_tgl;
      reply_oe_out <= tm_s2;
    end
  end

  assign reply_bit_out = reply;

  // ---------------- core domain ----------------
  // cleared in reset so ready reads high before the link side has left reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fr_s1   <= 1'b0;
      fr_s2   <= 1'b0;
      rack_s1 <= 1'b0;
      rack_s2 <= 1'b0;
    end else begin
      fr_s1   <= freq_tgl;
      fr_s2   <= fr_s1;
      rack_s1 <= rack_tgl;
      rack_s2 <= rack_s1;
    end
  end

  // frame_hold is stable while the toggles differ, so it is read directly
  assign do_wr = (fr_s2 != fack_tgl) && (fill != 2'h2);
  assign do_rd = frame_valid_out && frame_ready_in;

  always_comb begin
    next_wr_ptr   = do_wr ? ~wr_ptr : wr_ptr;
    next_rd_ptr   = do_rd ? ~rd_ptr : rd_ptr;
    next_fill     = fill + {1'b0, do_wr} - {1'b0, do_rd};
    next_fack_tgl = do_wr ? fr_s2 : fack_tgl;
    next_soft_rst = do_wr && test_mode_in && frame_hold[16:1] == RESET_CMD;
    next_rep_word = rep_word;
    next_rep_tgl  = rep_tgl;
    if (reply_valid_in && reply_ready_out) begin
      next_rep_word = reply_word_in;
      next_rep_tgl  = ~rep_tgl;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
      fill     <= 2'h0;
      fack_tgl <= 1'b0;
      rep_word <= WORD_RST;
      rep_tgl  <= 1'b0;
      soft_rst <= 1'b0;
      buf_mem[0] <= FRAME_RST;
      buf_mem[1] <= FRAME_RST;
    end else if (ce_in) begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      fill     <= next_fill;
      fack_tgl <= next_fack_tgl;
      rep_word <= next_rep_word;
      rep_tgl  <= next_rep_tgl;
      soft_rst <= next_soft_rst;
      if (do_wr)
        buf_mem[wr_ptr] <= frame_hold;
    end
  end

  assign frame_valid_out = (fill != 2'h0);
  assign frame_data_out  = buf_mem[rd_ptr][16:1];
  assign frame_stop_out  = buf_mem[rd_ptr][0];
  assign reply_ready_out = (rep_tgl == rack_s2);
  assign soft_reset_out  = soft_rst;
endmodule

// ===== hdl/spsp_pkg.sv
package spsp_pkg;
  localparam int          WORD_BITS     = 16;
  localparam int          FRAME_BITS    = 17;
  localparam int          CNT_W         = 20;
  localparam int          LINK_PERIOD_PS = 6000;
  localparam int          EOW_LOW_US    = 200;
  // least time rounds up to whole link clock cycles
  localparam int          EOW_CYCLES_DEF =
    (EOW_LOW_US * 1000000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam logic [4:0]  NBITS_RST     = 5'h00;
  localparam logic [4:0]  NBITS_FULL    = 5'h11;
  localparam logic [4:0]  TX_LEFT_LOAD  = 5'h0F;
  localparam logic [15:0] RESET_CMD     = 16'hA5C3;
  localparam logic [15:0] WORD_RST      = 16'h0000;
  localparam logic [16:0] FRAME_RST     = 17'h00000;
  localparam logic        REPLY_IDLE    = 1'b1;
  typedef enum logic [1:0] {SPSP_IDLE, SPSP_HIGH, SPSP_LOW} spsp_state_t;
endpackage

// ===== bench/spsp_port_sva.sv
`timescale 1ns/100ps
module spsp_port_sva (
  // watched ports
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        test_mode_in,
  input wire logic        reply_oe_out,
  input wire logic        frame_valid_out,
  input wire logic        frame_ready_in,
  input wire logic [15:0] frame_data_out,
  input wire logic        frame_stop_out,
  input wire logic        reply_valid_in,
  input wire logic        reply_ready_out,
  input wire logic        soft_reset_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |=>
    !frame_valid_out && !soft_reset_out && reply_ready_out)
    else $error("outputs not quiet in reset");
  a_oe_reset: assert property (disable iff (1'b0) !rst_n_in [*4] |-> !reply_oe_out)
    else $error("pin driven in reset");
  a_oe_off: assert property (!test_mode_in [*8] |-> !reply_oe_out)
    else $error("pin driven outside test mode");
  a_no_frame_off: assert property (!test_mode_in [*8] |-> !$rose(frame_valid_out))
    else $error("frame taken outside test mode");
  a_frame_hold: assert property (frame_valid_out && !frame_ready_in |=>
    frame_valid_out && $stable(frame_data_out) && $stable(frame_stop_out))
    else $error("head frame changed while stalled");
  a_ready_drop: assert property (reply_valid_in && reply_ready_out |=> !reply_ready_out)
    else $error("reply ready stayed high after accept");
  a_srst_pulse: assert property (soft_reset_out |=> !soft_reset_out)
    else $error("soft reset longer than one cycle");
  a_srst_test: assert property (soft_reset_out |-> $past(test_mode_in))
    else $error("soft reset outside test mode");
  c_frame: cover property (frame_valid_out && frame_ready_in);
  c_reply: cover property (reply_valid_in && reply_ready_out);
  c_srst: cover property (soft_reset_out);
endmodule
bind spsp_port spsp_port_sva u_sva (.clk_in, .rst_n_in, .test_mode_in, .reply_oe_out,
  .frame_valid_out, .frame_ready_in, .frame_data_out, .frame_stop_out, .reply_valid_in,
  .reply_ready_out, .soft_reset_out);

// ===== bench/spsp_prog_model.sv
`timescale 1ns/100ps
module spsp_prog_model #(
  parameter int EOW = 50
) (
  // link side
  input  wire logic link_clk_in,
  input  wire logic reply_bit_in,
  output logic      supply_high_out
);
  initial supply_high_out = 1'b0;
  // one pulse, reply read late in the high phase once the pin has settled
  task automatic pulse(input int h, input int l, output logic r);
    supply_high_out <= 1'b1;
    repeat (h) @(posedge link_clk_in);
    r = reply_bit_in;
    supply_high_out <= 1'b0;
    repeat (l) @(posedge link_clk_in);
  endtask
  // bit period shortened to 30 link clocks to keep runs short
  task automatic send_frame(input logic [15:0] d, input logic extra, output logic [16:0] rep);
    logic r;
    @(posedge link_clk_in);
    if (extra) pulse(20, 10, r);
    for (int i = 15; i >= 0; i--) begin
      pulse(d[i] ? 20 : 10, d[i] ? 10 : 20, r);
      rep[i + 1] = r;
    end
    // stop bit high beats any low; one comparator, so no 30 us mid level
    pulse(25, EOW + 10, r);
    rep[0] = r;
  endtask
endmodule

// ===== bench/test_supply_pulse_serial_port.sv
`timescale 1ns/100ps
module test_supply_pulse_serial_port;
  import spsp_pkg::*;
  localparam int EOW = 50;
  logic                 clk_in = 1'b0;
  logic                 link_clk = 1'b0;
  logic                 rst_n_in = 1'b0;
  logic                 test_mode = 1'b0;
  logic                 supply;
  logic                 reply_bit;
  logic                 oe;
  logic                 f_valid;
  logic                 f_ready = 1'b0;
  logic [WORD_BITS-1:0] f_data;
  logic                 f_stop;
  logic                 r_valid = 1'b0;
  logic                 r_ready;
  logic [WORD_BITS-1:0] r_word = WORD_RST;
  logic                 srst;
  int                   error_cnt = 0;
  int                   compares = 0;
  int                   seed = 13239;
  int                   srst_cnt = 0;
  logic [16:0]          rep;
  logic [15:0]          w;
  logic [15:0]          q[$];
  always #5 clk_in = ~clk_in;
  always #3 link_clk = ~link_clk;
  spsp_port #(.EOW_CYCLES(EOW)) DUT (.clk_in, .rst_n_in, .ce_in(1'b1),
    .test_mode_in(test_mode), .link_clk_in(link_clk), .supply_high_in(supply),
    .reply_bit_out(reply_bit), .reply_oe_out(oe), .frame_valid_out(f_valid),
    .frame_ready_in(f_ready), .frame_data_out(f_data), .frame_stop_out(f_stop),
    .reply_valid_in(r_valid), .reply_ready_out(r_ready), .reply_word_in(r_word),
    .soft_reset_out(srst));
  spsp_prog_model #(.EOW(EOW)) u_prog (.link_clk_in(link_clk), .reply_bit_in(reply_bit),
    .supply_high_out(supply));
  always @(posedge clk_in) if (srst === 1'b1) srst_cnt <= srst_cnt + 1;
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // a good frame carries the word and a stop bit read as one
  function automatic logic [16:0] exp_frame(input logic [15:0] d);
    return {d, 1'b1};
  endfunction
  task automatic give_verdict;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // sampled at the falling edge so register updates have landed
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (s !== 1'b1 && n < 300);
    if (s !== 1'b1) begin
      chk(17'h0, 17'h1);
      give_verdict();
    end
  endtask
  task automatic take(input logic [15:0] d);
    wait_hi(f_valid);
    chk({f_data, f_stop}, exp_frame(d));
    @(posedge clk_in);
    f_ready <= 1'b1;
    @(posedge clk_in);
    f_ready <= 1'b0;
  endtask
  // the link loads the word only when idle, so wait for ready to return
  task automatic offer(input logic [15:0] d);
    @(posedge clk_in);
    r_word <= d;
    r_valid <= 1'b1;
    wait_hi(r_ready);
    @(posedge clk_in);
    r_valid <= 1'b0;
    repeat (2) @(negedge clk_in);
    wait_hi(r_ready);
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    u_prog.send_frame(16'h1234, 1'b0, rep);
    repeat (10) @(negedge clk_in);
    chk({16'h0, f_valid}, 17'h0);
    chk({16'h0, oe}, 17'h0);
    @(posedge clk_in);
    test_mode <= 1'b1;
    repeat (10) @(negedge clk_in);
    chk({16'h0, oe}, 17'h1);
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($random(seed));
      offer(~w);
      u_prog.send_frame(w, 1'b0, rep);
      chk(rep, exp_frame(~w));
      take(w);
    end
    u_prog.send_frame(w, 1'b1, rep);
    take(w);
    u_prog.send_frame(RESET_CMD, 1'b0, rep);
    take(RESET_CMD);
    chk(17'(srst_cnt), 17'h1);
    // consumer stalls: two buffered, one held at the link, the fourth is lost
    for (int i = 0; i < 4; i++) begin
      q.push_back(16'($random(seed)));
      u_prog.send_frame(q[i], 1'b0, rep);
    end
    chk(rep, 17'h1FFFF);
    for (int i = 0; i < 3; i++) take(q[i]);
    repeat (20) @(negedge clk_in);
    chk({16'h0, f_valid}, 17'h0);
    give_verdict();
  end
endmodule
